// ===== pkg/timer_pkg.sv
/*
 * Shared constants of the three-channel timer counter: register offsets,
 * field positions, reset values and prescaler tap masks.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package timer_pkg;
	localparam int          ADDR_W      = 8;
	localparam int          CNT_W       = 8;
	localparam int          PRE_W       = 12;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_MODE0   = 8'h04;
	localparam logic [7:0]  OFS_MODE1   = 8'h08;
	localparam logic [7:0]  OFS_MODE2   = 8'h0c;
	localparam logic [7:0]  OFS_MOD0    = 8'h10;
	localparam logic [7:0]  OFS_MOD1    = 8'h14;
	localparam logic [7:0]  OFS_MOD2    = 8'h18;
	localparam logic [7:0]  OFS_MOD2H   = 8'h1c;
	localparam logic [7:0]  OFS_CNT0    = 8'h20;
	localparam logic [7:0]  OFS_CNT1    = 8'h24;
	localparam logic [7:0]  OFS_CNT2    = 8'h28;
	localparam logic [7:0]  OFS_CTRL2   = 8'h2c;
	localparam logic [7:0]  OFS_STAT    = 8'h30;
	localparam logic [7:0]  OFS_MASK    = 8'h34;
	localparam logic [7:0]  OFS_PDIR    = 8'h38;
	localparam logic [7:0]  OFS_PORT    = 8'h3c;
	// field positions
	localparam int          CTRL_RUN_LSB = 0;
	localparam int          CTRL_OE_LSB  = 4;
	localparam int          MODE_SEL_LSB = 2;
	localparam int          CTRL2_CARR   = 0;
	// mode pair encodings
	localparam logic [1:0]  PAIR_8BIT   = 2'h0;
	localparam logic [1:0]  PAIR_PWM    = 2'h1;
	localparam logic [1:0]  PAIR_16BIT  = 2'h2;
	localparam logic [1:0]  PAIR_CARR   = 2'h3;
	// reset values
	localparam logic [7:0]  MOD_RST     = 8'hff;
	localparam logic [4:0]  MODE_RST    = 5'h00;
	// prescaler taps: system clock over 2^5, 2^6, 2^8, 2^10, 2^12
	localparam logic [11:0] TAP_5       = 12'h01f;
	localparam logic [11:0] TAP_6       = 12'h03f;
	localparam logic [11:0] TAP_8       = 12'h0ff;
	localparam logic [11:0] TAP_10      = 12'h3ff;
	localparam logic [11:0] TAP_12      = 12'hfff;
	// bus responses
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ===== src/timer_chan.sv
/*
 * One 8-bit count register with its output toggle flip-flop.
 * Assumes the parent gates hit with the channel's run state and its
 * selected comparator; tick is gated with run here.
 */
`timescale 1ns/1ns
module timer_chan
	import timer_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             start,
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic             hit,
	output logic      [CNT_W-1:0] count,
	output logic                  tout
);
	logic [CNT_W-1:0] next_count;
	logic             next_tout;

	// restart, compare-clear with toggle, or increment
	always_comb begin
		next_count = count;
		next_tout  = tout;
		if (start) begin
			next_count = '0;
		end else if (hit) begin
			next_count = '0;
			next_tout  = ~tout;
		end else if (run && tick) begin
			next_count = count + 8'h01;
		end
	end

	// counter and flip-flop clear on reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count <= '0;
			tout  <= 1'b0;
		end else begin
			count <= next_count;
			tout  <= next_tout;
		end
	end
endmodule

// ===== src/timer_counter.sv
/*
 * Three-channel 8-bit timer counter with AXI4-Lite registers, sticky
 * match interrupts and three timer output pins shared with port bits.
 * Assumes one clock, synchronous active-high reset, synchronous pins.
 */
`timescale 1ns/1ns
// Overview of operation
// - three channels each own a count, modulo, comparator and toggle.
// - each channel is an interval timer raising a match interrupt.
// - each channel can drive a square wave on its own timer pin.
// - count registers read back at any time without disturbing counts.
// - mode pairs of channels 1 and 2 select 8-bit, pwm, 16-bit, carrier.
// - pulse-width generation exists only on channel 2.
// - in 16-bit mode channel 1 reloads and toggles on the joint match of both counts with mod1 and mod2.
// - a channel 1 match sets its request flag; a clear resets it.
// - pin 1 carries the toggle only while its output enable is set.
// - reset loads all modulo registers with ones, clears the rest.
module timer_counter
	import timer_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   irq,
	input  wire logic              timer_out_pin0_in,
	output logic                   timer_out_pin0_out,
	output logic                   timer_out_pin0_oe,
	input  wire logic              timer_out_pin1_in,
	output logic                   timer_out_pin1_out,
	output logic                   timer_out_pin1_oe,
	input  wire logic              timer_out_pin2_in,
	output logic                   timer_out_pin2_out,
	output logic                   timer_out_pin2_oe
);
	// software registers
	logic [6:0]       ctrl;
	logic [4:0]       chan0_mode_reg;
	logic [4:0]       chan1_mode_reg;
	logic [4:0]       chan2_mode_reg;
	logic [7:0]       mod0;
	logic [7:0]       mod1;
	logic [7:0]       mod2;
	logic [7:0]       chan2_high_period_modulo;
	logic [6:0]       chan2_control_reg;
	logic [2:0]       irq_stat;
	logic [2:0]       irq_mask;
	logic [2:0]       port_dir_group_a;
	logic [2:0]       port_latch;
	logic [6:0]       next_ctrl;
	logic [4:0]       next_mode0;
	logic [4:0]       next_mode1;
	logic [4:0]       next_mode2;
	logic [7:0]       next_mod0;
	logic [7:0]       next_mod1;
	logic [7:0]       next_mod2;
	logic [7:0]       next_mod2h;
	logic [6:0]       next_ctrl2;
	logic [2:0]       next_irq_stat;
	logic [2:0]       next_irq_mask;
	logic [2:0]       next_pdir;
	logic [2:0]       next_port_latch;
	// bus state
	logic             aw_held;
	logic             w_held;
	logic [7:0]       waddr_q;
	logic [31:0]      wdata_q;
	logic             wstrb0_q;
	logic             next_aw_held;
	logic             next_w_held;
	logic [7:0]       next_waddr_q;
	logic [31:0]      next_wdata_q;
	logic             next_wstrb0_q;
	logic [1:0]       next_bresp;
	logic             next_bvalid;
	logic [31:0]      next_rdata;
	logic [1:0]       next_rresp;
	logic             next_rvalid;
	// timer datapath
	logic [PRE_W-1:0] presc;
	logic [2:0]       start;
	logic [2:0]       tick;
	logic [2:0]       hit;
	logic [2:0]       tout;
	logic [7:0]       cnt [3];
	logic [7:0]       cmp2;
	logic             mode16;
	logic             pwm2;
	logic             carr;
	logic             ev16;
	logic [2:0]       ev;
	logic             wr_fire;
	logic [2:0]       next_pin_out;
	logic [2:0]       pin_in;
	logic [2:0]       chan1_match_event_v;

	// prescaler tick for a three-bit clock select
	function automatic logic sel_tick(input logic [2:0] sel,
		input logic [PRE_W-1:0] p);
		logic [PRE_W-1:0] m;
		m = TAP_12;
		case (sel)
			3'h0: m = TAP_5;
			3'h1: m = TAP_6;
			3'h2: m = TAP_8;
			3'h3: m = TAP_10;
			default: m = TAP_12;
		endcase
		return (p & m) == m;
	endfunction

	// address decode shared by reads and writes
	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= OFS_PORT);
	endfunction

	// mode decode of the two mode pairs
	assign mode16 = chan1_mode_reg[1:0] == PAIR_16BIT &&
		chan2_mode_reg[1:0] == PAIR_16BIT;
	assign pwm2   = chan1_mode_reg[1:0] == PAIR_8BIT &&
		chan2_mode_reg[1:0] == PAIR_PWM;
	assign carr   = chan1_mode_reg[1:0] == PAIR_8BIT &&
		chan2_mode_reg[1:0] == PAIR_CARR;
	assign pin_in = {timer_out_pin2_in, timer_out_pin1_in,
		timer_out_pin0_in};

	// free-running prescaler shared by all channels
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			presc <= '0;
		end else begin
			presc <= presc + 12'h001;
		end
	end

	// ticks, comparators and match events
	assign wr_fire  = aw_held && w_held && !bvalid;
	assign start    = (wr_fire && wstrb0_q && waddr_q == OFS_CTRL) ?
		wdata_q[2:0] : 3'h0;
	assign cmp2     = (pwm2 || carr) && tout[2] ?
		chan2_high_period_modulo : mod2;
	assign tick[0]  = sel_tick(chan0_mode_reg[4:2], presc);
	assign tick[2]  = sel_tick(chan2_mode_reg[4:2], presc);
	assign tick[1]  = mode16 ? (tick[2] && cnt[2] == 8'hff) :
		sel_tick(chan1_mode_reg[4:2], presc);
	assign ev16     = ctrl[2] && tick[2] &&
		{cnt[1], cnt[2]} == {mod1, mod2};
	assign hit[0]   = ctrl[0] && tick[0] && cnt[0] == mod0;
	assign hit[1]   = mode16 ? ev16 :
		ctrl[1] && tick[1] && cnt[1] == mod1;
	assign hit[2]   = mode16 ? ev16 :
		ctrl[2] && tick[2] && cnt[2] == cmp2;
	assign chan1_match_event_v = {1'b0, hit[1], 1'b0};
	assign ev       = hit;

	// three identical channels
	for (genvar i = 0; i < 3; i++) begin : g_chan
		timer_chan u_chan (
			.clk     (clk),
			.sys_rst (sys_rst),
			.start   (i == 1 && mode16 ? start[2] : start[i]),
			.run     (i == 1 && mode16 ? ctrl[2] : ctrl[i]),
			.tick    (tick[i]),
			.hit     (hit[i]),
			.count   (cnt[i]),
			.tout    (tout[i])
		);
	end

	// write channel: hold address and data, then commit and respond
	always_comb begin
		next_aw_held  = aw_held;
		next_w_held   = w_held;
		next_waddr_q  = waddr_q;
		next_wdata_q  = wdata_q;
		next_wstrb0_q = wstrb0_q;
		next_bresp    = bresp;
		next_bvalid   = bvalid;
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_waddr_q = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held   = 1'b1;
			next_wdata_q  = wdata;
			next_wstrb0_q = wstrb[0];
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = is_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// read channel: one-cycle answer with live register values
	always_comb begin
		next_rdata  = rdata;
		next_rresp  = rresp;
		next_rvalid = rvalid;
		if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			case (araddr)
				OFS_CTRL:  next_rdata = {25'h0, ctrl};
				OFS_MODE0: next_rdata = {27'h0, chan0_mode_reg};
				OFS_MODE1: next_rdata = {27'h0, chan1_mode_reg};
				OFS_MODE2: next_rdata = {27'h0, chan2_mode_reg};
				OFS_MOD0:  next_rdata = {24'h0, mod0};
				OFS_MOD1:  next_rdata = {24'h0, mod1};
				OFS_MOD2:  next_rdata = {24'h0, mod2};
				OFS_MOD2H: next_rdata = {24'h0, chan2_high_period_modulo};
				OFS_CNT0:  next_rdata = {24'h0, cnt[0]};
				OFS_CNT1:  next_rdata = {24'h0, cnt[1]};
				OFS_CNT2:  next_rdata = {24'h0, cnt[2]};
				OFS_CTRL2: next_rdata = {25'h0, chan2_control_reg};
				OFS_STAT:  next_rdata = {29'h0, irq_stat};
				OFS_MASK:  next_rdata = {29'h0, irq_mask};
				OFS_PDIR:  next_rdata = {29'h0, port_dir_group_a};
				OFS_PORT:  next_rdata = {29'h0, pin_in};
				default:   next_rdata = 32'h0;
			endcase
		end
	end

	// register file updates and sticky status
	always_comb begin
		next_ctrl       = ctrl;
		next_mode0      = chan0_mode_reg;
		next_mode1      = chan1_mode_reg;
		next_mode2      = chan2_mode_reg;
		next_mod0       = mod0;
		next_mod1       = mod1;
		next_mod2       = mod2;
		next_mod2h      = chan2_high_period_modulo;
		next_ctrl2      = chan2_control_reg;
		next_irq_mask   = irq_mask;
		next_pdir       = port_dir_group_a;
		next_port_latch = port_latch;
		next_irq_stat   = irq_stat;
		if (wr_fire && wstrb0_q) begin
			case (waddr_q)
				OFS_CTRL:  next_ctrl = wdata_q[6:0];
				OFS_MODE0: next_mode0 = {wdata_q[4:2], 2'h0};
				OFS_MODE1: next_mode1 = wdata_q[4:0];
				OFS_MODE2: next_mode2 = wdata_q[4:0];
				OFS_MOD0:  next_mod0 = wdata_q[7:0];
				OFS_MOD1:  next_mod1 = wdata_q[7:0];
				OFS_MOD2:  next_mod2 = wdata_q[7:0];
				OFS_MOD2H: next_mod2h = wdata_q[7:0];
				OFS_CTRL2: next_ctrl2 = wdata_q[6:0];
				OFS_STAT:  next_irq_stat = irq_stat & ~wdata_q[2:0];
				OFS_MASK:  next_irq_mask = wdata_q[2:0];
				OFS_PDIR:  next_pdir = wdata_q[2:0];
				OFS_PORT:  next_port_latch = wdata_q[2:0];
				default:   next_ctrl = ctrl;
			endcase
		end
		next_irq_stat = next_irq_stat | ev;
	end

	// pin drive: toggle when enabled, else the port latch
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_pin_out[i] = ctrl[CTRL_OE_LSB + i] ? tout[i] :
				port_latch[i];
		end
		if (carr && ctrl[CTRL_OE_LSB + 2] &&
			chan2_control_reg[CTRL2_CARR]) begin
			next_pin_out[2] = tout[2] & tout[1]; // carrier gated
		end
	end

	// all registered state except the prescaler and the channel counts and toggles
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl                     <= '0;
			chan0_mode_reg           <= MODE_RST;
			chan1_mode_reg           <= MODE_RST;
			chan2_mode_reg           <= MODE_RST;
			mod0                     <= MOD_RST;
			mod1                     <= MOD_RST;
			mod2                     <= MOD_RST;
			chan2_high_period_modulo <= MOD_RST;
			chan2_control_reg        <= '0;
			irq_stat                 <= '0;
			irq_mask                 <= '0;
			port_dir_group_a         <= '0;
			port_latch               <= '0;
			aw_held                  <= 1'b0;
			w_held                   <= 1'b0;
			waddr_q                  <= '0;
			wdata_q                  <= '0;
			wstrb0_q                 <= 1'b0;
			awready                  <= 1'b0;
			wready                   <= 1'b0;
			bresp                    <= RESP_OKAY;
			bvalid                   <= 1'b0;
			arready                  <= 1'b0;
			rdata                    <= '0;
			rresp                    <= RESP_OKAY;
			rvalid                   <= 1'b0;
			irq                      <= 1'b0;
			timer_out_pin0_out       <= 1'b0;
			timer_out_pin0_oe        <= 1'b0;
			timer_out_pin1_out       <= 1'b0;
			timer_out_pin1_oe        <= 1'b0;
			timer_out_pin2_out       <= 1'b0;
			timer_out_pin2_oe        <= 1'b0;
		end else begin
			ctrl                     <= next_ctrl;
			chan0_mode_reg           <= next_mode0;
			chan1_mode_reg           <= next_mode1;
			chan2_mode_reg           <= next_mode2;
			mod0                     <= next_mod0;
			mod1                     <= next_mod1;
			mod2                     <= next_mod2;
			chan2_high_period_modulo <= next_mod2h;
			chan2_control_reg        <= next_ctrl2;
			irq_stat                 <= next_irq_stat;
			irq_mask                 <= next_irq_mask;
			port_dir_group_a         <= next_pdir;
			port_latch               <= next_port_latch;
			aw_held                  <= next_aw_held;
			w_held                   <= next_w_held;
			waddr_q                  <= next_waddr_q;
			wdata_q                  <= next_wdata_q;
			wstrb0_q                 <= next_wstrb0_q;
			awready                  <= !next_aw_held;
			wready                   <= !next_w_held;
			bresp                    <= next_bresp;
			bvalid                   <= next_bvalid;
			arready                  <= !next_rvalid;
			rdata                    <= next_rdata;
			rresp                    <= next_rresp;
			rvalid                   <= next_rvalid;
			irq                      <= |(next_irq_stat & irq_mask);
			timer_out_pin0_out       <= next_pin_out[0];
			timer_out_pin0_oe        <= port_dir_group_a[0];
			timer_out_pin1_out       <= next_pin_out[1];
			timer_out_pin1_oe        <= port_dir_group_a[1];
			timer_out_pin2_out       <= next_pin_out[2];
			timer_out_pin2_oe        <= port_dir_group_a[2];
		end
	end

	// checks on the timer and bus behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence wr_both_taken;
		awvalid && awready && wvalid && wready && !bvalid;
	endsequence

	sequence ch1_match;
		!mode16 && chan1_match_event_v[1];
	endsequence

	AST_START_CLEARS: assert property (start[0] |=> cnt[0] == 8'h00)
		else $error("start did not clear channel 0 count");
	AST_MOD_RESET: assert property ($past(sys_rst) |->
		mod2 == 8'hff && chan2_high_period_modulo == 8'hff)
		else $error("modulo not all ones after reset");
	AST_IRQ_SET: assert property (ch1_match |=> irq_stat[1])
		else $error("channel 1 match did not set its flag");
	AST_PIN1_TOGGLE: assert property (ctrl[5] |=>
		timer_out_pin1_out == $past(tout[1]))
		else $error("pin 1 not following toggle");
	AST_COUNT_INC: assert property (ctrl[0] && tick[0] && !hit[0] &&
		!start[0] |=> cnt[0] == $past(cnt[0]) + 8'h01)
		else $error("channel 0 count did not increment");
	AST_WRAP_TOGGLE: assert property (hit[0] && !start[0] |=>
		cnt[0] == 8'h00 && tout[0] != $past(tout[0]))
		else $error("channel 0 match did not clear and toggle");
	AST_CASCADE: assert property (mode16 && ev16 && start == 3'h0 |=>
		cnt[1] == 8'h00 && cnt[2] == 8'h00)
		else $error("16-bit match did not reload both halves");
	AST_PWM_HIGH: assert property (pwm2 && tout[2] && hit[2] |->
		cnt[2] == chan2_high_period_modulo)
		else $error("pwm high period compare wrong");
	AST_WRITE_RESP: assert property (wr_both_taken |-> ##2 bvalid)
		else $error("write response not two cycles after take");
	AST_READ_CNT: assert property (arvalid && arready &&
		araddr == OFS_CNT1 |=> rvalid && rdata[7:0] == $past(cnt[1]))
		else $error("count readback wrong");
endmodule

// ===== tb/testbench.sv
/*
 * Self-checking bench of the three-channel timer counter: bus tasks that
 * queue expected answers, a monitor that compares them, mode scenarios.
 * Assumes timer_pkg constants and the pin model in timer_pins.
 */
`timescale 1ns/1ns
module testbench
	import timer_pkg::*;
;
	logic              clk, sys_rst, irq, ext_en;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, last_rd;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp;
	logic [2:0]        pin_in, pin_out, pin_oe, ext;
	logic [1:0]        bq[$];
	logic [65:0]       rq[$];
	logic [65:0]       rexp;
	int                n_mismatch, checks_done, n, m;

	// design and its pin side
	timer_counter i_timer_counter (
		.clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .irq,
		.timer_out_pin0_in(pin_in[0]), .timer_out_pin0_out(pin_out[0]),
		.timer_out_pin0_oe(pin_oe[0]), .timer_out_pin1_in(pin_in[1]),
		.timer_out_pin1_out(pin_out[1]), .timer_out_pin1_oe(pin_oe[1]),
		.timer_out_pin2_in(pin_in[2]), .timer_out_pin2_out(pin_out[2]),
		.timer_out_pin2_oe(pin_oe[2])
	);
	timer_pins i_timer_pins (.pin_out, .pin_oe, .ext, .ext_en, .pin_in);

	// 250 MHz clock
	always #2 clk = ~clk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tmo();
		n_mismatch++;
		end_of_test();
	endtask

	// bus write: address and data offered together, response awaited
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		int   i = 0;
		logic ap = 1'b1;
		logic wp = 1'b1;
		logic bp = 1'b1;
		@(posedge clk);
		bq.push_back(er);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (i < 50 && bp) begin
			@(posedge clk);
			i++;
			if (ap && awready) begin
				awvalid <= 1'b0;
				ap = 1'b0;
			end
			if (wp && wready) begin
				wvalid <= 1'b0;
				wp = 1'b0;
			end
			if (bvalid) begin
				bready <= 1'b0;
				bp = 1'b0;
			end
		end
		if (bp) tmo();
	endtask

	// bus read: expected data under a mask is queued for the monitor
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [31:0] mk = 32'hffffffff,
		input logic [1:0] er = RESP_OKAY);
		int   i = 0;
		logic ap = 1'b1;
		logic rp = 1'b1;
		@(posedge clk);
		rq.push_back({er, mk, ed});
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (i < 50 && rp) begin
			@(posedge clk);
			i++;
			if (ap && arready) begin
				arvalid <= 1'b0;
				ap = 1'b0;
			end
			if (rvalid) begin
				rready <= 1'b0;
				rp = 1'b0;
				last_rd = rdata;
			end
		end
		if (rp) tmo();
	endtask

	// takes the oldest queued note whenever a response is handed over
	always @(posedge clk) begin
		if (bvalid && bready && bq.size() > 0)
			chk({30'h0, bresp}, {30'h0, bq.pop_front()});
		if (rvalid && rready && rq.size() > 0) begin
			rexp = rq.pop_front();
			chk(rdata & rexp[63:32], rexp[31:0]);
			chk({30'h0, rresp}, {30'h0, rexp[65:64]});
		end
	end

	// length of the next full phase of level v on pin k, in clocks
	task automatic lvl_len(input int k, input logic v, output int len);
		int i = 0;
		len = 0;
		while (i < 30000 && pin_out[k] === v) begin
			@(posedge clk);
			i++;
		end
		while (i < 30000 && pin_out[k] !== v) begin
			@(posedge clk);
			i++;
		end
		while (i < 30000 && pin_out[k] === v) begin
			@(posedge clk);
			i++;
			len++;
		end
		if (i >= 30000) tmo();
	endtask

	task automatic wait_irq(input int lim);
		int i = 0;
		while (i < lim && irq !== 1'b1) begin
			@(posedge clk);
			i++;
		end
		if (i >= lim) tmo();
	endtask

	// every register after reset, pins idle, port reads the pin levels
	task automatic rst_vals();
		logic [7:0] ofs [16] = '{OFS_CTRL, OFS_MODE0, OFS_MODE1, OFS_MODE2,
			OFS_MOD0, OFS_MOD1, OFS_MOD2, OFS_MOD2H, OFS_CNT0, OFS_CNT1,
			OFS_CNT2, OFS_CTRL2, OFS_STAT, OFS_MASK, OFS_PDIR, OFS_PORT};
		for (int i = 0; i < 15; i++)
			rd(ofs[i], (i >= 4 && i < 8) ? 32'hff : 32'h0);
		rd(ofs[15], {29'h0, ext});
		chk({31'h0, irq}, 32'h0);
		chk({26'h0, pin_oe, pin_out}, 32'h0);
	endtask

	initial begin
		static logic [1:0] pr [4][2] = '{'{PAIR_8BIT, PAIR_8BIT},
			'{PAIR_8BIT, PAIR_PWM}, '{PAIR_16BIT, PAIR_16BIT},
			'{PAIR_8BIT, PAIR_CARR}};
		clk = 1'b0;
		sys_rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
		void'($urandom(17701));
		ext = 3'($urandom());
		ext_en = 1'b1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rst_vals();
		// unmapped and unaligned places answer with an error
		rd(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h40, 32'h5, RESP_SLVERR);
		wr(8'h02, 32'h5, RESP_SLVERR);
		// software keeps the reserved bits at zero
		wr(OFS_MODE0, 32'h1c);
		rd(OFS_MODE0, 32'h1c);
		wr(OFS_CTRL2, 32'h7f);
		rd(OFS_CTRL2, 32'h7f);
		wr(OFS_CTRL2, 32'h0);
		wr(OFS_MODE0, 32'h0);
		// a write with byte lane 0 off is answered but changes nothing
		wstrb <= 4'h0;
		wr(OFS_MOD0, 32'h12);
		rd(OFS_MOD0, 32'hff);
		wstrb <= 4'hf;
		// each of the four mode pair settings, random clock select on channel 2
		for (int i = 0; i < 4; i++) begin
			m = $urandom_range(4, 0);
			wr(OFS_MODE1, {30'h0, pr[i][0]});
			wr(OFS_MODE2, {27'h0, 3'(m), pr[i][1]});
			rd(OFS_MODE1, {30'h0, pr[i][0]});
			rd(OFS_MODE2, {27'h0, 3'(m), pr[i][1]});
		end
		wr(OFS_MODE1, 32'h0);
		wr(OFS_MODE2, 32'h0);
		// channel 0 interval interrupt, masking and clearing
		wr(OFS_MOD0, 32'h1);
		wr(OFS_MASK, 32'h1);
		wr(OFS_CTRL, 32'h1);
		wait_irq(400);
		rd(OFS_STAT, 32'h1, 32'h1);
		wr(OFS_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STAT, 32'h1);
		wr(OFS_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(OFS_STAT, 32'h0, 32'h7);
		// readback while counting, then a restart from zero
		wr(OFS_MOD0, 32'hff);
		wr(OFS_CTRL, 32'h1);
		repeat (400) @(posedge clk);
		rd(OFS_CNT0, 32'h0, 32'h0);
		n = last_rd;
		rd(OFS_CNT0, 32'h0, 32'h0);
		chk({31'h0, last_rd >= n && n > 8}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_CNT0, 32'h0, 32'h0);
		chk({31'h0, last_rd <= 1}, 32'h1);
		wr(OFS_CTRL, 32'h0);
		// channel 1 square wave on its pin, latch shown while disabled
		m = $urandom_range(3, 0);
		wr(OFS_MOD1, 32'(m));
		wr(OFS_MODE1, 32'h4);
		wr(OFS_PDIR, 32'h2);
		wr(OFS_PORT, 32'h2);
		repeat (2) @(posedge clk);
		chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
		wr(OFS_MASK, 32'h2);
		wr(OFS_CTRL, 32'h22);
		lvl_len(1, 1'b1, n);
		chk(32'(n), 32'((m + 1) * 64));
		chk({31'h0, irq}, 32'h1);
		rd(OFS_STAT, 32'h2, 32'h2);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STAT, 32'h2);
		rd(OFS_STAT, 32'h0, 32'h2);
		// channel 2 pulse width: high and low phases from two moduli
		wr(OFS_MOD2H, 32'h2);
		wr(OFS_MOD2, 32'h5);
		wr(OFS_MODE2, {30'h0, PAIR_PWM});
		wr(OFS_PDIR, 32'h4);
		wr(OFS_CTRL, 32'h44);
		lvl_len(2, 1'b1, n);
		chk(32'(n), 32'd96);
		lvl_len(2, 1'b0, n);
		chk(32'(n), 32'd192);
		// carrier pair without gating keeps the two-modulo waveform
		wr(OFS_MODE2, {30'h0, PAIR_CARR});
		wr(OFS_CTRL, 32'h44);
		lvl_len(2, 1'b1, n);
		chk(32'(n), 32'd96);
		wr(OFS_CTRL, 32'h0);
		// 16-bit cascade: no low-byte match, one joint match later
		wr(OFS_STAT, 32'h7);
		wr(OFS_MODE1, {30'h0, PAIR_16BIT});
		wr(OFS_MODE2, {30'h0, PAIR_16BIT});
		wr(OFS_MOD1, 32'h1);
		wr(OFS_MOD2, 32'h0);
		wr(OFS_MASK, 32'h6);
		wr(OFS_CTRL, 32'h4);
		repeat (640) @(posedge clk);
		rd(OFS_STAT, 32'h0, 32'h6);
		wait_irq(9000);
		rd(OFS_STAT, 32'h6, 32'h6);
		// second reset in mid-run
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rst_vals();
		end_of_test();
	end
endmodule

// ===== tb/timer_pins.sv
/*
 * Pin side of the timer: resolves each shared timer pin from the block's
 * drive, an outside driver and the board pull-up.
 * Assumes the bench keeps its outside driver enabled; the block's drive overrides it on output pins.
 */
`timescale 1ns/1ns
module timer_pins (
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe,
	input  wire logic [2:0] ext,
	input  wire logic       ext_en,
	output logic      [2:0] pin_in
);
	// block drive wins, then the outside driver, else the pull-up level
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			if (pin_oe[k])
				pin_in[k] = pin_out[k];
			else if (ext_en)
				pin_in[k] = ext[k];
			else
				pin_in[k] = 1'b1;
		end
	end
endmodule
